/* File: design/sgt_pkg.sv */
// constants, register map and mode codes of the speed-loop gain tuner
// assumes one drive clock; parameter port is a simple word write/read strobe pair
// Function
// - mode codes 0 manual, 1 auto, 2 semi
// - manual mode uses user-written gains unchanged
// - auto/semi to manual copies measured gains
// - auto estimates inertia, stores every 30 minutes
// - auto to manual copies position, prop, integral
// - semi to manual copies five measured gains
// - semi settles: stable flag, stop, store ratio
// - semi excessive inertia: clear flag, resume estimating
// - keep adjusting gains a while after store
// - prop gain 16 bit, default 500, 0..8191
// - integral gain 16 bit, default 100, 0..1023
// - feedforward 16 bit percent, default 0, 0..100
// - response level is stored and read back only; adjust period is fixed
// - mode selector 16 bit, default 0, 0..2
package sgt_pkg;
    localparam logic [15:0] ADDR_POS_GAIN = 16'h0200;
    localparam logic [15:0] ADDR_POS_FF = 16'h0202;
    localparam logic [15:0] ADDR_PROP = 16'h0208;
    localparam logic [15:0] ADDR_INTEG = 16'h020c;
    localparam logic [15:0] ADDR_FF = 16'h020e;
    localparam logic [15:0] ADDR_LPF = 16'h0232;
    localparam logic [15:0] ADDR_DIST = 16'h0234;
    localparam logic [15:0] ADDR_RESP = 16'h023e;
    localparam logic [15:0] ADDR_MODE = 16'h0240;
    localparam logic [15:0] ADDR_STABLE = 16'h0242;
    localparam logic [15:0] ADDR_INERTIA = 16'h014a;
    localparam logic [15:0] PROP_RST = 16'h01f4;
    localparam logic [15:0] INTEG_RST = 16'h0064;
    localparam logic [15:0] FF_RST = 16'h0000;
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [15:0] PROP_MAX = 16'h1fff;
    localparam logic [15:0] INTEG_MAX = 16'h03ff;
    localparam logic [15:0] FF_MAX = 16'h0064;
    localparam logic [15:0] MODE_MAX = 16'h0002;
    localparam logic [15:0] MODE_MANUAL = 16'h0000;
    localparam logic [15:0] MODE_AUTO = 16'h0001;
    localparam logic [15:0] MODE_SEMI = 16'h0002;
    localparam longint SAVE_MIN = 30;
    localparam longint CLK_HZ = 100000000;
    localparam longint SAVE_CYC = SAVE_MIN * 60 * CLK_HZ;
    localparam logic [7:0] ADJ_HOLD_CYC = 8'h40;
endpackage : sgt_pkg

/* File: design/sgt_param_ram.sv */
// small parameter store for the gain words; read data registered
// assumes single clock, one write and one read port
`timescale 1ns/100ps
module sgt_param_ram
(
    input wire logic clk_i,
    input wire logic ce_i,
    input wire logic we_i,
    input wire logic [2:0] waddr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [2:0] raddr_i,
    output logic [15:0] rdata_o
);
    logic [15:0] mem_r [0:7];
    always_ff @(posedge clk_i)
    begin
        if (ce_i && we_i)
        begin
            mem_r[waddr_i] <= wdata_i;
        end
        if (ce_i)
        begin
            rdata_o <= mem_r[raddr_i];
        end
    end
endmodule : sgt_param_ram

/* File: design/sgt_tuner.sv */
// speed-loop gain tuner: parameter port, mode selector, inertia tracking
// assumes estimator supplies inertia estimate, settled and excess levels in this clock
`timescale 1ns/100ps
module sgt_tuner
#(
    parameter longint SAVE_CYCLES = sgt_pkg::SAVE_CYC
)
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [15:0] est_inertia_i,
    input wire logic est_settled_i,
    input wire logic est_excess_i,
    input wire logic [15:0] meas_pos_gain_i,
    input wire logic [15:0] meas_prop_i,
    input wire logic [15:0] meas_integ_i,
    input wire logic [15:0] meas_lpf_i,
    input wire logic [15:0] meas_dist_i,
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    output logic wr_rej_o,
    output logic [15:0] prop_gain_o,
    output logic [15:0] integ_gain_o,
    output logic [15:0] ff_gain_o,
    output logic [15:0] tuning_mode_field_o,
    output logic inertia_stable_flag_o,
    output logic estimating_o,
    output logic adjusting_o,
    output logic inertia_saved_o
);
    ////////////////////////////////////////////////////////////////////////
    logic [15:0] prop_r, integ_r, ff_r, mode_r, inertia_r, resp_r;
    logic [15:0] mode_prev_r;
    logic stable_r;
    logic [63:0] save_cnt_r;
    logic [7:0] hold_r;
    logic rd_d_r;
    logic [2:0] ram_sel_r;
    logic [15:0] reg_rdata_r;
    logic save_pulse_r;
    logic [15:0] ram_rdata;
    logic estimating_r;
    logic adjusting_r;

    function automatic logic in_range(input logic [15:0] v, input logic [15:0] mx);
        in_range = (v <= mx);
    endfunction : in_range

    wire hit_prop = addr_i == sgt_pkg::ADDR_PROP;
    wire hit_integ = addr_i == sgt_pkg::ADDR_INTEG;
    wire hit_ff = addr_i == sgt_pkg::ADDR_FF;
    wire hit_mode = addr_i == sgt_pkg::ADDR_MODE;
    wire hit_inertia = addr_i == sgt_pkg::ADDR_INERTIA;
    wire hit_resp = addr_i == sgt_pkg::ADDR_RESP;
    wire hit_stable = addr_i == sgt_pkg::ADDR_STABLE;
    wire hit_pos = addr_i == sgt_pkg::ADDR_POS_GAIN;
    wire hit_posff = addr_i == sgt_pkg::ADDR_POS_FF;
    wire hit_lpf = addr_i == sgt_pkg::ADDR_LPF;
    wire hit_dist = addr_i == sgt_pkg::ADDR_DIST;
    wire hit_ram = hit_pos | hit_posff | hit_lpf | hit_dist;
    // ram words: 0 pos gain, 1 pos ff, 2 lpf, 3 disturbance
    wire [2:0] ram_addr = hit_pos ? 3'h0 : hit_posff ? 3'h1 : hit_lpf ? 3'h2 : 3'h3;

    // out-of-range writes are dropped; value held
    wire prop_ok = in_range(wdata_i, sgt_pkg::PROP_MAX);
    wire integ_ok = in_range(wdata_i, sgt_pkg::INTEG_MAX);
    wire ff_ok = in_range(wdata_i, sgt_pkg::FF_MAX);
    wire mode_ok = in_range(wdata_i, sgt_pkg::MODE_MAX);
    wire bad_wr = wr_i & ((hit_prop & ~prop_ok) | (hit_integ & ~integ_ok)
                  | (hit_ff & ~ff_ok) | (hit_mode & ~mode_ok));

    wire is_auto = mode_r == sgt_pkg::MODE_AUTO;
    wire is_semi = mode_r == sgt_pkg::MODE_SEMI;
    wire to_manual = (mode_r == sgt_pkg::MODE_MANUAL) && (mode_prev_r != sgt_pkg::MODE_MANUAL);
    wire from_auto = to_manual && (mode_prev_r == sgt_pkg::MODE_AUTO);
    wire from_semi = to_manual && (mode_prev_r == sgt_pkg::MODE_SEMI);
    wire est_run = is_auto | (is_semi & ~stable_r);
    wire save_due = is_auto && (save_cnt_r >= SAVE_CYCLES - 1);
    wire semi_settle = is_semi & ~stable_r & est_settled_i;
    wire semi_excess = is_semi & stable_r & est_excess_i;
    wire store_now = save_due | semi_settle;
    // copy of measured words into ram on leaving the auto modes
    wire cp_pos = from_auto | from_semi;
    wire cp_ram_we = cp_pos | from_semi;
    wire ram_we = (wr_i & hit_ram) | cp_ram_we;
    // one ram write per cycle: lpf/dist on semi exit take the next two cycles
    logic [1:0] cp_step_r;
    wire [2:0] ram_waddr = (wr_i & hit_ram) ? ram_addr :
                           cp_step_r == 2'h1 ? 3'h2 : cp_step_r == 2'h2 ? 3'h3 : 3'h0;
    wire [15:0] ram_wdata = (wr_i & hit_ram) ? wdata_i :
                            cp_step_r == 2'h1 ? meas_lpf_i :
                            cp_step_r == 2'h2 ? meas_dist_i : meas_pos_gain_i;

    ////////////////////////////////////////////////////////////////////////
    sgt_param_ram u_ram
    (
        .clk_i(clk_i),
        .ce_i(ce_i),
        .we_i(ram_we | (cp_step_r != 2'h0)),
        .waddr_i(ram_waddr),
        .wdata_i(ram_wdata),
        .raddr_i(ram_addr),
        .rdata_o(ram_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            prop_r <= sgt_pkg::PROP_RST;
            integ_r <= sgt_pkg::INTEG_RST;
            ff_r <= sgt_pkg::FF_RST;
            mode_r <= sgt_pkg::MODE_RST;
            mode_prev_r <= sgt_pkg::MODE_RST;
            inertia_r <= 16'h0000;
            resp_r <= 16'h0000;
            stable_r <= 1'b0;
            save_cnt_r <= 64'h0000_0000_0000_0000;
            hold_r <= 8'h00;
            cp_step_r <= 2'h0;
            estimating_r <= 1'b0;
            adjusting_r <= 1'b0;
        end
        else if (ce_i)
        begin
            mode_prev_r <= mode_r;
            // manual mode: gains only move by user writes
            if (wr_i && hit_prop && prop_ok) prop_r <= wdata_i;
            else if (cp_pos) prop_r <= meas_prop_i;
            if (wr_i && hit_integ && integ_ok) integ_r <= wdata_i;
            else if (cp_pos) integ_r <= meas_integ_i;
            if (wr_i && hit_ff && ff_ok) ff_r <= wdata_i;
            if (wr_i && hit_mode && mode_ok) mode_r <= wdata_i;
            if (wr_i && hit_resp) resp_r <= wdata_i;
            // estimator ratio stored on auto save or semi settle; host write otherwise
            if (store_now) inertia_r <= est_inertia_i;
            else if (wr_i && hit_inertia) inertia_r <= wdata_i;
            cp_step_r <= from_semi ? 2'h1 : cp_step_r == 2'h1 ? 2'h2 : 2'h0;
            if (!is_semi || semi_excess) stable_r <= 1'b0;
            else if (semi_settle) stable_r <= 1'b1;
            if (!is_auto || save_due) save_cnt_r <= 64'h0000_0000_0000_0000;
            else save_cnt_r <= save_cnt_r + 64'h0000_0000_0000_0001;
            // adjustment tail after each store
            if (store_now) hold_r <= sgt_pkg::ADJ_HOLD_CYC;
            else if (!(is_auto | is_semi)) hold_r <= 8'h00;
            else if (hold_r != 8'h00) hold_r <= hold_r - 8'h01;
            // status pins from flops: one cycle behind mode and flag
            estimating_r <= est_run;
            adjusting_r <= est_run | (hold_r != 8'h00);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rd_d_r <= 1'b0;
            ram_sel_r <= 3'h0;
            reg_rdata_r <= 16'h0000;
            rdata_o <= 16'h0000;
            rvalid_o <= 1'b0;
            wr_rej_o <= 1'b0;
            save_pulse_r <= 1'b0;
        end
        else if (ce_i)
        begin
            rd_d_r <= rd_i;
            ram_sel_r <= {2'b00, rd_i & hit_ram};
            reg_rdata_r <= hit_prop ? prop_r : hit_integ ? integ_r : hit_ff ? ff_r :
                           hit_mode ? mode_r : hit_inertia ? inertia_r :
                           hit_resp ? resp_r : hit_stable ? {15'h0000, stable_r} : 16'h0000;
            rvalid_o <= rd_d_r;
            rdata_o <= ram_sel_r[0] ? ram_rdata : reg_rdata_r;
            wr_rej_o <= bad_wr;
            save_pulse_r <= store_now;
        end
    end

    assign prop_gain_o = prop_r;
    assign integ_gain_o = integ_r;
    assign ff_gain_o = ff_r;
    assign tuning_mode_field_o = mode_r;
    assign inertia_stable_flag_o = stable_r;
    assign inertia_saved_o = save_pulse_r;
    assign estimating_o = estimating_r;
    assign adjusting_o = adjusting_r;

    ////////////////////////////////////////////////////////////////////////
    sequence s_leave_auto;
        mode_prev_r == sgt_pkg::MODE_AUTO && mode_r == sgt_pkg::MODE_MANUAL;
    endsequence
    sequence s_leave_semi;
        mode_prev_r == sgt_pkg::MODE_SEMI && mode_r == sgt_pkg::MODE_MANUAL;
    endsequence

    a_prop_range: assert property (@(posedge clk_i) disable iff (srst_i)
        ce_i && wr_i && hit_prop && prop_ok |=> prop_r == $past(wdata_i))
        else $error("prop gain write lost");
    a_reject_keep: assert property (@(posedge clk_i) disable iff (srst_i)
        ce_i && wr_i && hit_integ && !integ_ok |=> integ_r == $past(integ_r))
        else $error("bad integral write stored");
    a_ff_max: assert property (@(posedge clk_i) disable iff (srst_i)
        ff_r <= sgt_pkg::FF_MAX) else $error("feedforward out of range");
    a_mode_max: assert property (@(posedge clk_i) disable iff (srst_i)
        mode_r <= sgt_pkg::MODE_MAX) else $error("mode out of range");
    a_auto_copy: assert property (@(posedge clk_i) disable iff (srst_i)
        ((ce_i && !(wr_i && hit_prop)) and s_leave_auto) |=> prop_r == $past(meas_prop_i))
        else $error("auto exit copy missing");
    a_semi_copy: assert property (@(posedge clk_i) disable iff (srst_i)
        (ce_i and s_leave_semi) |=> cp_step_r == 2'h1) else $error("semi exit copy missing");
    a_stable_set: assert property (@(posedge clk_i) disable iff (srst_i)
        ce_i && semi_settle && !(wr_i && hit_mode) |=> stable_r && inertia_r == $past(est_inertia_i))
        else $error("stable flag not set");
    a_stable_clr: assert property (@(posedge clk_i) disable iff (srst_i)
        ce_i && semi_excess |=> !stable_r) else $error("stable flag not cleared");
    a_manual_hold: assert property (@(posedge clk_i) disable iff (srst_i)
        ce_i && mode_r == sgt_pkg::MODE_MANUAL && mode_prev_r == sgt_pkg::MODE_MANUAL
        && !(wr_i && hit_prop) |=> $stable(prop_r)) else $error("manual gain moved");
    a_adjust_tail: assert property (@(posedge clk_i) disable iff (srst_i)
        ce_i && store_now |=> hold_r == sgt_pkg::ADJ_HOLD_CYC) else $error("no adjust tail");
endmodule : sgt_tuner

/* File: verification/sgt_plant_model.sv */
// plant model: motor and load seen through the inertia estimator
// assumes the bench commands settling and excess inertia by level
`timescale 1ns/100ps
module sgt_plant_model
(
    input wire logic clk_i,
    input wire logic settle_i,
    input wire logic excess_i,
    output logic [15:0] inertia_o,
    output logic settled_o,
    output logic excess_o,
    output logic [15:0] meas_pos_o,
    output logic [15:0] meas_prop_o,
    output logic [15:0] meas_integ_o,
    output logic [15:0] meas_lpf_o,
    output logic [15:0] meas_dist_o
);
    logic [2:0] cnt_r = 3'h0;
    logic [15:0] est_r = 16'h0010;
    // estimate drifts until settled, so a stale store shows
    assign inertia_o = est_r;
    assign settled_o = (cnt_r == 3'h4);
    assign excess_o = excess_i;
    assign meas_pos_o = 16'h0123;
    assign meas_prop_o = 16'h0456;
    assign meas_integ_o = 16'h0078;
    assign meas_lpf_o = 16'h0011;
    assign meas_dist_o = 16'h0022;
    always_ff @(posedge clk_i)
    begin
        // excess knocks the estimate out of its settled state
        cnt_r <= (!settle_i || excess_i) ? 3'h0 : (settled_o ? cnt_r : cnt_r + 3'h1);
        est_r <= settled_o ? est_r : est_r + 16'h0001;
    end
endmodule : sgt_plant_model

/* File: verification/speed_loop_gain_tuner_bench.sv */
// self-checking bench of the gain tuner with a plant model
// assumes save interval shortened to 20 cycles
`timescale 1ns/100ps
module speed_loop_gain_tuner_bench;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce_i = 1'b1;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [15:0] wdata_i = 16'h0000;
    logic settle = 1'b0;
    logic excess = 1'b0;
    logic [15:0] inertia, rdata, prop, integ, ff, mode;
    logic [15:0] meas [5];
    logic settled, exc, rvalid, rej, stable, est, adj, saved;
    int miscompares = 0;
    int tests_run = 0;
    int cyc = 0;
    sgt_plant_model plant (.clk_i(clk_i), .settle_i(settle), .excess_i(excess),
        .inertia_o(inertia), .settled_o(settled), .excess_o(exc), .meas_pos_o(meas[0]),
        .meas_prop_o(meas[1]), .meas_integ_o(meas[2]), .meas_lpf_o(meas[3]),
        .meas_dist_o(meas[4]));
    sgt_tuner #(.SAVE_CYCLES(20)) dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
        .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .est_inertia_i(inertia), .est_settled_i(settled), .est_excess_i(exc),
        .meas_pos_gain_i(meas[0]), .meas_prop_i(meas[1]), .meas_integ_i(meas[2]),
        .meas_lpf_i(meas[3]), .meas_dist_i(meas[4]), .rdata_o(rdata),
        .rvalid_o(rvalid), .wr_rej_o(rej), .prop_gain_o(prop), .integ_gain_o(integ),
        .ff_gain_o(ff), .tuning_mode_field_o(mode), .inertia_stable_flag_o(stable),
        .estimating_o(est), .adjusting_o(adj), .inertia_saved_o(saved));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t %s", $time, what);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic r);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1 chk({15'h0000, rej}, {15'h0000, r}, "write refusal");
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(posedge clk_i);
        #1 chk({15'h0000, rvalid}, 16'h0001, "read valid");
        chk(rdata, exp, "read data");
    endtask : rd
    // bounded wait: sel 0 store pulse, sel 1 stable flag
    task automatic wait_bit(input int sel);
        int n;
        n = 0;
        while ((sel == 0 ? saved : stable) !== 1'b1 && n < 40)
        begin
            @(posedge clk_i);
            #1 n++;
        end
        chk({15'h0000, sel == 0 ? saved : stable}, 16'h0001, "awaited bit");
    endtask : wait_bit
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk(prop, sgt_pkg::PROP_RST, "prop reset");
        chk(integ, sgt_pkg::INTEG_RST, "integ reset");
        chk(ff, sgt_pkg::FF_RST, "ff reset");
        chk(mode, sgt_pkg::MODE_RST, "mode reset");
        rd(sgt_pkg::ADDR_PROP, sgt_pkg::PROP_RST);
        rd(16'h0300, 16'h0000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_range;
        logic [15:0] a [3] = '{sgt_pkg::ADDR_PROP, sgt_pkg::ADDR_INTEG, sgt_pkg::ADDR_FF};
        logic [15:0] m [3] = '{sgt_pkg::PROP_MAX, sgt_pkg::INTEG_MAX, sgt_pkg::FF_MAX};
        for (int i = 0; i < 3; i++)
        begin
            wr(a[i], m[i], 1'b0);
            wr(a[i], m[i] + 16'h0001, 1'b1);
            rd(a[i], m[i]);
        end
        wr(sgt_pkg::ADDR_RESP, 16'h0005, 1'b0);
        rd(sgt_pkg::ADDR_RESP, 16'h0005);
        wr(sgt_pkg::ADDR_MODE, 16'h0003, 1'b1);
        chk(mode, sgt_pkg::MODE_MANUAL, "mode kept");
        $display("test range done");
    endtask : t_range
    task automatic t_manual;
        wr(sgt_pkg::ADDR_INTEG, 16'h0000, 1'b0);
        wr(sgt_pkg::ADDR_FF, 16'h0000, 1'b0);
        wr(sgt_pkg::ADDR_PROP, 16'h012c, 1'b0);
        wr(sgt_pkg::ADDR_INTEG, 16'h0032, 1'b0);
        // enable low must freeze the parameter port
        @(posedge clk_i);
        ce_i <= 1'b0;
        wr(sgt_pkg::ADDR_PROP, 16'h0001, 1'b0);
        chk(prop, 16'h012c, "frozen by enable");
        @(posedge clk_i);
        ce_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        #1 chk(prop, 16'h012c, "manual prop held");
        chk(integ, 16'h0032, "manual integ held");
        chk({15'h0000, est}, 16'h0000, "no estimation in manual");
        $display("test manual done");
    endtask : t_manual
    task automatic t_auto;
        wr(sgt_pkg::ADDR_MODE, sgt_pkg::MODE_AUTO, 1'b0);
        chk(mode, sgt_pkg::MODE_AUTO, "auto mode");
        wait_bit(0);
        chk({15'h0000, est}, 16'h0001, "auto estimates");
        #10 wait_bit(0);
        chk({15'h0000, adj}, 16'h0001, "adjusting after store");
        wr(sgt_pkg::ADDR_MODE, sgt_pkg::MODE_MANUAL, 1'b0);
        repeat (4) @(posedge clk_i);
        #1 chk(prop, meas[1], "prop copied");
        chk(integ, meas[2], "integ copied");
        rd(sgt_pkg::ADDR_POS_GAIN, meas[0]);
        $display("test auto done");
    endtask : t_auto
    task automatic t_semi;
        wr(sgt_pkg::ADDR_PROP, 16'h0005, 1'b0);
        wr(sgt_pkg::ADDR_POS_GAIN, 16'h0007, 1'b0);
        wr(sgt_pkg::ADDR_INERTIA, 16'h0020, 1'b0);
        wr(sgt_pkg::ADDR_MODE, sgt_pkg::MODE_SEMI, 1'b0);
        settle <= 1'b1;
        wait_bit(1);
        @(posedge clk_i);
        #1 chk({15'h0000, est}, 16'h0000, "estimation stopped");
        chk({15'h0000, adj}, 16'h0001, "adjust tail running");
        rd(sgt_pkg::ADDR_INERTIA, inertia);
        rd(sgt_pkg::ADDR_STABLE, 16'h0001);
        // tail loaded at the store edge, counted down to its last cycle
        repeat (57) @(posedge clk_i);
        #1 chk({15'h0000, adj}, 16'h0001, "tail last cycle");
        @(posedge clk_i);
        #1 chk({15'h0000, adj}, 16'h0000, "tail ended");
        excess <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1 chk({15'h0000, stable}, 16'h0000, "excess clears flag");
        chk({15'h0000, est}, 16'h0001, "estimation resumed");
        excess <= 1'b0;
        wr(sgt_pkg::ADDR_MODE, sgt_pkg::MODE_MANUAL, 1'b0);
        settle <= 1'b0;
        repeat (5) @(posedge clk_i);
        #1 chk(prop, meas[1], "semi prop copied");
        chk(integ, meas[2], "semi integ copied");
        rd(sgt_pkg::ADDR_POS_GAIN, meas[0]);
        rd(sgt_pkg::ADDR_LPF, meas[3]);
        rd(sgt_pkg::ADDR_DIST, meas[4]);
        $display("test semi done");
    endtask : t_semi
    task automatic conclude;
        $display("checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            miscompares++;
            conclude();
        end
    end
    initial
    begin
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        #1 t_reset();
        t_range();
        t_manual();
        t_auto();
        t_semi();
        conclude();
    end
endmodule : speed_loop_gain_tuner_bench
